//--- bench/branch_shift_flag_exec_assertions.sv
// bus level checker for the branch, shift and flag execution unit
`timescale 1ns/1ps
`default_nettype none
module branch_shift_flag_exec_assertions
    import branch_shift_flag_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    // shadow of flags, pc and command; trusted only when both were written before the command
    logic [7:0]  f_q;
    logic [15:0] p_q;
    logic [31:0] c_q;
    logic [1:0]  arm_q;
    logic        fresh_q;
    wire logic        done   = !avs_waitrequest && (avs_read || avs_write);
    wire logic        rd_ok  = done && avs_read && fresh_q;
    wire logic        pc_rd  = rd_ok && avs_address == PC_OFFSET;
    wire logic        flg_rd = rd_ok && avs_address == FLAGS_OFFSET;
    wire logic        res_rd = rd_ok && avs_address == RESULT_OFFSET;
    wire logic [4:0]  cmd_op = c_q[4:0];
    wire logic [15:0] seq_pc = p_q + 16'h0001;
    wire logic [15:0] br_pc  = p_q + {{9{c_q[22]}}, c_q[22:16]} + 16'h0001;
    wire logic        nxv    = f_q[FLAG_N] ^ f_q[FLAG_V];
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            f_q <= '0;
            p_q <= '0;
            c_q <= '0;
            arm_q <= '0;
            fresh_q <= 1'b0;
        end else if (done && avs_write) begin
            if (avs_address == FLAGS_OFFSET) begin
                f_q <= avs_writedata[7:0];
                arm_q[0] <= 1'b1;
                fresh_q <= 1'b0;
            end
            if (avs_address == PC_OFFSET) begin
                p_q <= avs_writedata[15:0];
                arm_q[1] <= 1'b1;
                fresh_q <= 1'b0;
            end
            if (avs_address == CMD_OFFSET) begin
                c_q <= avs_writedata;
                arm_q <= '0;
                fresh_q <= &arm_q;
            end
        end
    end
    property br_p(logic [4:0] code, logic cond);
        @(posedge clk_sys) disable iff (reset)
        pc_rd && cmd_op[4:1] == code[4:1] |-> avs_readdata == {16'h0000, cond ? br_pc : seq_pc};
    endproperty
    carry_branch_a: assert property (br_p(branch_carry_set, f_q[FLAG_C] ^ cmd_op[0]))
        else $error("carry branch pc wrong");
    unsigned_branch_a: assert property (br_p(branch_lower, f_q[FLAG_C] ^ ~cmd_op[0]))
        else $error("unsigned branch pc wrong");
    sign_branch_a: assert property (br_p(branch_minus, f_q[FLAG_N] ^ cmd_op[0]))
        else $error("sign branch pc wrong");
    signed_cmp_a: assert property (br_p(branch_signed_ge, nxv ^ ~cmd_op[0]))
        else $error("signed branch pc wrong");
    half_branch_a: assert property (br_p(branch_half_carry_set, f_q[FLAG_H] ^ cmd_op[0]))
        else $error("half carry branch pc wrong");
    t_branch_a: assert property (br_p(branch_t_set, f_q[FLAG_T] ^ cmd_op[0]))
        else $error("t branch pc wrong");
    ovf_branch_a: assert property (br_p(branch_overflow_set, f_q[FLAG_V] ^ cmd_op[0]))
        else $error("overflow branch pc wrong");
    irq_branch_a: assert property (br_p(branch_irq_enabled, f_q[FLAG_I] ^ cmd_op[0]))
        else $error("irq branch pc wrong");
    branch_flags_a: assert property (@(posedge clk_sys) disable iff (reset)
        flg_rd && cmd_op < 5'h10 |-> avs_readdata == {24'h00_0000, f_q})
        else $error("branch changed flags");
    lsl_result_a: assert property (@(posedge clk_sys) disable iff (reset)
        res_rd && cmd_op == logical_left_shift |-> avs_readdata == {24'h00_0000, c_q[14:8], 1'b0})
        else $error("left shift result wrong");
    swap_result_a: assert property (@(posedge clk_sys) disable iff (reset)
        res_rd && cmd_op == nibble_exchange |-> avs_readdata[7:0] == {c_q[11:8], c_q[15:12]})
        else $error("nibble exchange result wrong");
    cover property (@(posedge clk_sys) pc_rd && cmd_op < 5'h10 && avs_readdata[15:0] != seq_pc);
    cover property (@(posedge clk_sys) res_rd && cmd_op == nibble_exchange);
    cover property (@(posedge clk_sys) done && avs_write && avs_address[7]);
endmodule // branch_shift_flag_exec_assertions
bind branch_shift_flag_exec branch_shift_flag_exec_assertions chk (.clk_sys(clk_sys),
    .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

//--- bench/branch_shift_flag_exec_test.sv
// self-checking bench for the branch, shift and flag execution unit
`timescale 1ns/1ps
`default_nettype none
module branch_shift_flag_exec_test
    import branch_shift_flag_pkg::*;
;
    typedef struct packed {
        op_type op; logic [2:0] b; logic [7:0] rd; logic [6:0] k;
        logic [7:0] fi; logic [15:0] pc; logic [7:0] fo; logic [7:0] res;
    } row_type;
    // pc starts at 0x0010 in every row; untaken and non-branch rows land on 0x0011
    row_type rows [26] = '{
        '{branch_carry_set, 3'h0, 8'h00, 7'h05, 8'h01, 16'h0016, 8'h01, 8'h00},
        '{branch_carry_clear, 3'h0, 8'h00, 7'h05, 8'h01, 16'h0011, 8'h01, 8'h00},
        '{branch_same_higher, 3'h0, 8'h00, 7'h7E, 8'h00, 16'h000F, 8'h00, 8'h00},
        '{branch_lower, 3'h0, 8'h00, 7'h05, 8'h00, 16'h0011, 8'h00, 8'h00},
        '{branch_minus, 3'h0, 8'h00, 7'h03, 8'h04, 16'h0014, 8'h04, 8'h00},
        '{branch_plus, 3'h0, 8'h00, 7'h03, 8'h04, 16'h0011, 8'h04, 8'h00},
        '{branch_signed_ge, 3'h0, 8'h00, 7'h03, 8'h0C, 16'h0014, 8'h0C, 8'h00},
        '{branch_signed_lt, 3'h0, 8'h00, 7'h03, 8'h0C, 16'h0011, 8'h0C, 8'h00},
        '{branch_half_carry_set, 3'h0, 8'h00, 7'h3F, 8'h20, 16'h0050, 8'h20, 8'h00},
        '{branch_half_carry_clear, 3'h0, 8'h00, 7'h3F, 8'h20, 16'h0011, 8'h20, 8'h00},
        '{branch_t_set, 3'h0, 8'h00, 7'h40, 8'h40, 16'hFFD1, 8'h40, 8'h00},
        '{branch_t_clear, 3'h0, 8'h00, 7'h40, 8'h40, 16'h0011, 8'h40, 8'h00},
        '{branch_overflow_set, 3'h0, 8'h00, 7'h01, 8'h08, 16'h0012, 8'h08, 8'h00},
        '{branch_overflow_clear, 3'h0, 8'h00, 7'h01, 8'h08, 16'h0011, 8'h08, 8'h00},
        '{branch_irq_enabled, 3'h0, 8'h00, 7'h01, 8'h80, 16'h0012, 8'h80, 8'h00},
        '{branch_irq_disabled, 3'h0, 8'h00, 7'h01, 8'h80, 16'h0011, 8'h80, 8'h00},
        '{logical_left_shift, 3'h0, 8'h81, 7'h00, 8'h00, 16'h0011, 8'h09, 8'h02},
        '{logical_right_shift, 3'h0, 8'h01, 7'h00, 8'h00, 16'h0011, 8'h0B, 8'h00},
        '{rotate_left_carry, 3'h0, 8'h40, 7'h00, 8'h01, 16'h0011, 8'h0C, 8'h81},
        '{rotate_right_carry, 3'h0, 8'h02, 7'h00, 8'h01, 16'h0011, 8'h0C, 8'h81},
        '{arith_right_shift, 3'h0, 8'h81, 7'h00, 8'h10, 16'h0011, 8'h15, 8'hC0},
        '{nibble_exchange, 3'h0, 8'h3C, 7'h00, 8'hFF, 16'h0011, 8'hFF, 8'hC3},
        '{flag_index_set, 3'h4, 8'h00, 7'h00, 8'h00, 16'h0011, 8'h10, 8'hC3},
        '{flag_index_clear, 3'h6, 8'h00, 7'h00, 8'hFF, 16'h0011, 8'hBF, 8'hC3},
        '{bit_to_t_flag, 3'h5, 8'h20, 7'h00, 8'h00, 16'h0011, 8'h40, 8'h20},
        '{t_flag_to_bit, 3'h7, 8'h00, 7'h00, 8'h40, 16'h0011, 8'h40, 8'h80}
    };
    logic        clk_sys;
    logic        reset;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] q;
    int          lat;
    int          base;
    int          cycles;
    int          err_total;
    int          checks;
    branch_shift_flag_exec uut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    always #2 clk_sys = ~clk_sys;
    // one bus transfer; an idle edge follows so the next request never lands on the release edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        lat = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk_sys);
            lat++;
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        clk_sys = 1'b0;
        reset = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'hF;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        xfer(0, CMD_OFFSET, 0); chk(q, 32'h0000_001C);
        xfer(0, FLAGS_OFFSET, 0); chk(q, 32'h0000_0000);
        xfer(0, PC_OFFSET, 0); chk(q, 32'h0000_0000);
        xfer(0, 8'hFC, 0); chk(q, 32'h0000_0000);
        $display("test reset done");
        xfer(1, CMD_OFFSET, {27'h0, no_operation});
        xfer(0, PC_OFFSET, 0);
        base = lat;
        foreach (rows[i]) begin
            xfer(1, FLAGS_OFFSET, {24'h0, rows[i].fi});
            xfer(1, PC_OFFSET, 32'h0000_0010);
            xfer(1, CMD_OFFSET, {9'h0, rows[i].k, rows[i].rd, rows[i].b, rows[i].op});
            xfer(0, PC_OFFSET, 0); chk(q, {16'h0, rows[i].pc});
            chk(32'(lat), 32'(base + (rows[i].pc !== 16'h0011)));
            xfer(0, FLAGS_OFFSET, 0); chk(q, {24'h0, rows[i].fo});
            if (rows[i].op >= logical_left_shift) begin
                xfer(0, RESULT_OFFSET, 0); chk(q, {24'h0, rows[i].res});
            end
        end
        $display("test table done");
        for (int s = 0; s < 8; s++) begin
            xfer(1, FLAGS_OFFSET, 0);
            xfer(1, CMD_OFFSET, {24'h0, 3'(s), flag_index_set});
            xfer(0, FLAGS_OFFSET, 0); chk(q, 32'h1 << s);
            xfer(1, FLAGS_OFFSET, 32'h0000_00FF);
            xfer(1, CMD_OFFSET, {24'h0, 3'(s), flag_index_clear});
            xfer(0, FLAGS_OFFSET, 0); chk(q, 32'hFF & ~(32'h1 << s));
        end
        $display("test flags done");
        xfer(1, 8'hFC, 32'h0000_00A5);
        xfer(1, FLAGS_OFFSET, 32'h0000_005A);
        xfer(1, CMD_OFFSET, {8'h1F, 16'h0, 3'h1, io_bit_set});
        xfer(0, 8'hFC, 0); chk(q, 32'h0000_00A7);
        chk(32'(lat), 32'(base + 1));
        xfer(1, CMD_OFFSET, {8'h1F, 16'h0, 3'h7, io_bit_clear});
        xfer(0, 8'hFC, 0); chk(q, 32'h0000_0027);
        xfer(0, FLAGS_OFFSET, 0); chk(q, 32'h0000_005A);
        xfer(0, 8'h80, 0); chk(q, 32'h0000_0000);
        xfer(1, 8'h40, 32'h1234_5678);
        xfer(0, 8'h40, 0); chk(q, 32'h0000_0000);
        xfer(0, BUSY_OFFSET, 0); chk(q, 32'h0000_0000);
        xfer(1, PC_OFFSET, 32'h0000_1234);
        avs_byteenable <= 4'h1;
        xfer(1, PC_OFFSET, 32'h0000_56AB);
        avs_byteenable <= 4'hF;
        xfer(0, PC_OFFSET, 0); chk(q, 32'h0000_12AB);
        $display("test io done");
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        xfer(0, 8'hFC, 0); chk(q, 32'h0000_0000);
        xfer(0, PC_OFFSET, 0); chk(q, 32'h0000_0000);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule // branch_shift_flag_exec_test
`default_nettype wire

//--- core/branch_shift_flag_exec.sv
// execution unit for flag branches, io bit ops, shifts and flag operations
//
// Overview of operation
// - carry branches jump to pc+k+1, flags kept
// - same-or-higher on carry 0, lower on 1
// - minus on negative 1, plus on 0
// - signed ge/lt on negative xor overflow
// - half carry branches on half carry 1/0
// - t branches on t 1/0, flags kept
// - overflow branches on overflow 1/0
// - irq branches on global interrupt 1/0
// - io bit set/clear, two clocks, no flags
// - left shift, zero fill, updates z c n v
// - right shift, bit7 cleared, updates z c n v
// - rotate left, carry in bit0, out bit7
// - rotate right, carry in bit7, out bit0
// - arithmetic right shift keeps bit 7
// - bit to t, t to bit, one clock
// - each flag settable and clearable alone
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module branch_shift_flag_exec
    import branch_shift_flag_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest
);

    typedef struct packed {
        fsm_type                   fsm;
        logic                      waitrequest;
        logic [31:0]               readdata;
        logic [7:0]                flags;
        logic [15:0]               pc;
        logic [7:0]                result;
        op_type                    op;
        logic [2:0]                bit_sel;
        logic [7:0]                data;
        logic [6:0]                k;
        logic [4:0]                io_sel;
        logic [IO_COUNT-1:0][7:0]  io;
    } state_type;

    state_type s;
    state_type next_s;

    // byte lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // condition of each conditional branch
    function automatic logic branch_cond(input op_type op, input logic [7:0] f);
        case (op)
            branch_carry_set:        branch_cond = f[FLAG_C];
            branch_carry_clear:      branch_cond = !f[FLAG_C];
            branch_same_higher:      branch_cond = !f[FLAG_C];
            branch_lower:            branch_cond = f[FLAG_C];
            branch_minus:            branch_cond = f[FLAG_N];
            branch_plus:             branch_cond = !f[FLAG_N];
            branch_signed_ge:        branch_cond = !(f[FLAG_N] ^ f[FLAG_V]);
            branch_signed_lt:        branch_cond = f[FLAG_N] ^ f[FLAG_V];
            branch_half_carry_set:   branch_cond = f[FLAG_H];
            branch_half_carry_clear: branch_cond = !f[FLAG_H];
            branch_t_set:            branch_cond = f[FLAG_T];
            branch_t_clear:          branch_cond = !f[FLAG_T];
            branch_overflow_set:     branch_cond = f[FLAG_V];
            branch_overflow_clear:   branch_cond = !f[FLAG_V];
            branch_irq_enabled:      branch_cond = f[FLAG_I];
            branch_irq_disabled:     branch_cond = !f[FLAG_I];
            default:                 branch_cond = 1'b0;
        endcase
    endfunction

    function automatic logic is_branch(input op_type op);
        return op[4] == 1'b0;
    endfunction

    // command word as software sees it; bit 23 and bits 31:29 always read 0
    function automatic logic [31:0] cmd_word(input state_type st);
        return {3'b000, st.io_sel, 1'b0, st.k, st.data, st.bit_sel, st.op};
    endfunction

    // one bit of a byte forced to a value, shared by flag and t_flag_to_bit updates
    function automatic logic [7:0] put_bit(input logic [7:0] v,
                                           input logic [2:0] idx,
                                           input logic       b);
        logic [7:0] r;
        r      = v;
        r[idx] = b;
        return r;
    endfunction

    // relative target; pc is 16 bits and wraps, so a negative k near 0 lands high
    function automatic logic [15:0] rel_target(input logic [15:0] pc,
                                               input logic [6:0]  k);
        return pc + {{9{k[6]}}, k} + 16'h0001;
    endfunction

    // flags after a shift or rotate: only c, z, n and v move
    function automatic logic [7:0] shift_flags(input logic [7:0] f,
                                               input logic [7:0] r,
                                               input logic       c);
        logic [7:0] n;
        n         = f;
        n[FLAG_C] = c;
        n[FLAG_Z] = (r == 8'h00);
        n[FLAG_N] = r[7];
        n[FLAG_V] = r[7] ^ c;
        return n;
    endfunction

    logic [7:0]  shifted;
    logic        carry_out;
    logic        shift_op;
    logic [31:0] wmerge;
    logic [4:0]  io_idx;
    logic        io_hit;

    always_comb begin
        next_s    = s;
        shifted   = s.data;
        carry_out = s.flags[FLAG_C];
        shift_op  = 1'b0;
        io_idx    = avs_address[6:2];
        io_hit    = avs_address[7];
        wmerge    = 32'h0000_0000;
        case (s.fsm)
            st_idle: begin
                // requests wait while an instruction runs, so state is never read half done
                if ((avs_read || avs_write) && s.waitrequest) begin
                    next_s.waitrequest = 1'b0;
                    next_s.readdata    = 32'h0000_0000;
                    if (avs_read) begin
                        if (io_hit) begin
                            next_s.readdata[7:0] = s.io[io_idx];
                        end else begin
                            case (avs_address)
                                CMD_OFFSET:    next_s.readdata = cmd_word(s);
                                FLAGS_OFFSET:  next_s.readdata[7:0] = s.flags;
                                PC_OFFSET:     next_s.readdata[15:0] = s.pc;
                                RESULT_OFFSET: next_s.readdata[7:0] = s.result;
                                // busy always reads 0: accesses already wait out execution
                                BUSY_OFFSET:   next_s.readdata = 32'h0000_0000;
                                default:       next_s.readdata = 32'h0000_0000;
                            endcase
                        end
                    end
                end else if ((avs_read || avs_write) && !s.waitrequest) begin
                    // completion edge: the write takes effect here
                    next_s.waitrequest = 1'b1;
                    if (avs_write) begin
                        if (io_hit) begin
                            wmerge = merge({24'h00_0000, s.io[io_idx]}, avs_writedata,
                                           avs_byteenable);
                            next_s.io[io_idx] = wmerge[7:0];
                        end else begin
                            case (avs_address)
                                CMD_OFFSET: begin
                                    wmerge = merge(cmd_word(s), avs_writedata, avs_byteenable);
                                    next_s.op      = op_type'(wmerge[CMD_OP_LSB +: 5]);
                                    next_s.bit_sel = wmerge[CMD_BIT_LSB +: 3];
                                    next_s.data    = wmerge[CMD_DATA_LSB +: 8];
                                    next_s.k       = wmerge[CMD_K_LSB +: 7];
                                    next_s.io_sel  = wmerge[CMD_IO_LSB +: 5];
                                    next_s.fsm     = st_exec;
                                end
                                FLAGS_OFFSET: begin
                                    wmerge = merge({24'h00_0000, s.flags}, avs_writedata,
                                                   avs_byteenable);
                                    next_s.flags = wmerge[7:0];
                                end
                                PC_OFFSET: begin
                                    wmerge = merge({16'h0000, s.pc}, avs_writedata,
                                                   avs_byteenable);
                                    next_s.pc = wmerge[15:0];
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                end
            end
            st_exec: begin
                next_s.fsm = st_idle;
                next_s.pc  = s.pc + 16'h0001;
                case (s.op)
                    io_bit_set, io_bit_clear: begin
                        next_s.pc  = s.pc;
                        next_s.fsm = st_final;
                    end
                    logical_left_shift: begin
                        shifted   = {s.data[6:0], 1'b0};
                        carry_out = s.data[7];
                        shift_op  = 1'b1;
                    end
                    logical_right_shift: begin
                        shifted   = {1'b0, s.data[7:1]};
                        carry_out = s.data[0];
                        shift_op  = 1'b1;
                    end
                    rotate_left_carry: begin
                        shifted   = {s.data[6:0], s.flags[FLAG_C]};
                        carry_out = s.data[7];
                        shift_op  = 1'b1;
                    end
                    rotate_right_carry: begin
                        shifted   = {s.flags[FLAG_C], s.data[7:1]};
                        carry_out = s.data[0];
                        shift_op  = 1'b1;
                    end
                    arith_right_shift: begin
                        shifted   = {s.data[7], s.data[7:1]};
                        carry_out = s.data[0];
                        shift_op  = 1'b1;
                    end
                    nibble_exchange: begin
                        next_s.result = {s.data[3:0], s.data[7:4]};
                    end
                    flag_index_set: begin
                        next_s.flags = put_bit(s.flags, s.bit_sel, 1'b1);
                    end
                    flag_index_clear: begin
                        next_s.flags = put_bit(s.flags, s.bit_sel, 1'b0);
                    end
                    bit_to_t_flag: begin
                        next_s.flags[FLAG_T] = s.data[s.bit_sel];
                        next_s.result        = s.data;
                    end
                    t_flag_to_bit: begin
                        next_s.result = put_bit(s.data, s.bit_sel, s.flags[FLAG_T]);
                    end
                    default: begin
                        // an untaken branch ends here and falls through
                        if (is_branch(s.op) && branch_cond(s.op, s.flags)) begin
                            next_s.pc  = s.pc;
                            next_s.fsm = st_final;
                        end
                    end
                endcase
                // the signed flag is left alone: only z c n v follow a shift
                if (shift_op) begin
                    next_s.result = shifted;
                    next_s.flags  = shift_flags(s.flags, shifted, carry_out);
                end
            end
            st_final: begin
                next_s.fsm = st_idle;
                if (is_branch(s.op)) begin
                    next_s.pc = rel_target(s.pc, s.k);
                end else begin
                    next_s.io[s.io_sel][s.bit_sel] = (s.op == io_bit_set);
                    next_s.pc = s.pc + 16'h0001;
                end
            end
            default: begin
                next_s.fsm = st_idle;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s             <= '0;
            s.fsm         <= st_idle;
            s.waitrequest <= 1'b1;
            s.flags       <= FLAGS_RESET;
            s.pc          <= PC_RESET;
            s.result      <= RESULT_RESET;
            s.op          <= no_operation;
            s.io          <= {IO_COUNT{IO_RESET}};
        end else begin
            s <= next_s;
        end
    end

    assign avs_readdata    = s.readdata;
    assign avs_waitrequest = s.waitrequest;

endmodule // branch_shift_flag_exec

`default_nettype wire

//--- pkg/branch_shift_flag_pkg.sv
// constants and types shared by the branch, shift and flag execution unit
package branch_shift_flag_pkg;

    // register byte offsets on the avalon slave
    localparam logic [7:0] CMD_OFFSET    = 8'h00;
    localparam logic [7:0] FLAGS_OFFSET  = 8'h04;
    localparam logic [7:0] PC_OFFSET     = 8'h08;
    localparam logic [7:0] RESULT_OFFSET = 8'h0C;
    localparam logic [7:0] BUSY_OFFSET   = 8'h10;
    localparam int         IO_COUNT      = 32;

    // command word field positions
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_BIT_LSB  = 5;
    localparam int CMD_DATA_LSB = 8;
    localparam int CMD_K_LSB    = 16;
    localparam int CMD_IO_LSB   = 24;

    // status flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // reset values
    localparam logic [7:0]  FLAGS_RESET  = 8'h00;
    localparam logic [15:0] PC_RESET     = 16'h0000;
    localparam logic [7:0]  RESULT_RESET = 8'h00;
    localparam logic [7:0]  IO_RESET     = 8'h00;

    typedef enum logic [4:0] {
        branch_carry_set        = 5'h00,
        branch_carry_clear      = 5'h01,
        branch_same_higher      = 5'h02,
        branch_lower            = 5'h03,
        branch_minus            = 5'h04,
        branch_plus             = 5'h05,
        branch_signed_ge        = 5'h06,
        branch_signed_lt        = 5'h07,
        branch_half_carry_set   = 5'h08,
        branch_half_carry_clear = 5'h09,
        branch_t_set            = 5'h0A,
        branch_t_clear          = 5'h0B,
        branch_overflow_set     = 5'h0C,
        branch_overflow_clear   = 5'h0D,
        branch_irq_enabled      = 5'h0E,
        branch_irq_disabled     = 5'h0F,
        io_bit_set              = 5'h10,
        io_bit_clear            = 5'h11,
        logical_left_shift      = 5'h12,
        logical_right_shift     = 5'h13,
        rotate_left_carry       = 5'h14,
        rotate_right_carry      = 5'h15,
        arith_right_shift       = 5'h16,
        nibble_exchange         = 5'h17,
        flag_index_set          = 5'h18,
        flag_index_clear        = 5'h19,
        bit_to_t_flag           = 5'h1A,
        t_flag_to_bit           = 5'h1B,
        no_operation            = 5'h1C
    } op_type;

    typedef enum logic [2:0] {
        st_idle  = 3'b001,
        st_exec  = 3'b010,
        st_final = 3'b100
    } fsm_type;

endpackage
